// ===== verilog/arl_defines.svh
// Purpose: Constants for the ADC serial readout lanes block
// Assumes: Output control byte layout as decoded by arl_readout_lanes
// Notes:   Offsets here are bit positions inside the control byte
`ifndef ARL_DEFINES_SVH
`define ARL_DEFINES_SVH

`define ARL_WORD_BITS        22
`define ARL_LANES            4
`define ARL_FIFO_DEPTH       4
`define ARL_CNT_W            5

// Output control byte fields
`define ARL_MODE_LSB         0
`define ARL_WIDTH_LSB        2
`define ARL_RATE_BIT         4
`define ARL_SRCSEL_LSB       6
`define ARL_OUT_CTRL_RESET   8'h00
`define ARL_IN_PROTO_RESET   2'h0

// Whole-byte values that keep daisy-chain behaviour
`define ARL_CTRL_DAISY_A     8'h00
`define ARL_CTRL_DAISY_B     8'h01

// Output mode field codes
`define ARL_MODE_STD         2'h0
`define ARL_MODE_EARLY       2'h1
`define ARL_MODE_SRC         2'h3

// Lane count field codes
`define ARL_WIDTH_DUAL       2'h2
`define ARL_WIDTH_QUAD       2'h3

// Source clock select codes and internal half periods in clk_in cycles
`define ARL_SRC_SCLK         2'h0
`define ARL_SRC_INT          2'h1
`define ARL_SRC_DIV2         2'h2
`define ARL_SRC_DIV4         2'h3
`define ARL_HALF_INT         3'h1
`define ARL_HALF_DIV2        3'h2
`define ARL_HALF_DIV4        3'h4

// Groups needed to move a whole word at 1, 2 and 4 lanes
`define ARL_GROUPS_1         5'h16
`define ARL_GROUPS_2         5'h0B
`define ARL_GROUPS_4         5'h06

`endif

// ===== verilog/arl_pkg.sv
// Purpose: Types shared by the readout lanes design
// Assumes: Field layout matches arl_defines.svh
// Notes:   Control struct is packed in register bit order
package arl_pkg;

    typedef struct packed {
        logic [1:0] source_clock_select;
        logic       reserved;
        logic       data_rate;
        logic [1:0] output_lane_count;
        logic [1:0] output_mode_field;
    } arl_out_ctrl_t;

    typedef enum logic [2:0] {
        ARL_ST_IDLE = 3'b001,
        ARL_ST_SPI  = 3'b010,
        ARL_ST_SRC  = 3'b100
    } arl_state_t;

endpackage

// ===== verilog/arl_fifo.sv
// Purpose: Small word FIFO between conversion results and the serial port
// Assumes: Single clock, synchronous active-low reset
// Notes:   Flags are registered so the write ready leaves a flip-flop
module arl_fifo #(
    parameter int WIDTH = 22,
    parameter int DEPTH = 4
) (
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    input  wire logic [WIDTH-1:0] in_data_in,
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    output logic [WIDTH-1:0]      out_data_out,
    output logic                  out_valid_out,
    input  wire logic             out_ready_in
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic             push;
    logic             pop;
    logic [AW:0]      next_count;

    assign push = in_valid_in && in_ready_out;
    assign pop  = out_valid_out && out_ready_in;
    assign out_data_out = mem[rd_ptr];

    always_comb begin
        next_count = count;
        if (push && !pop) begin
            next_count = count + 1'b1;
        end else if (pop && !push) begin
            next_count = count - 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            count         <= '0;
            in_ready_out  <= 1'b1;
            out_valid_out <= 1'b0;
        end else begin
            count         <= next_count;
            in_ready_out  <= (next_count != (AW+1)'(DEPTH));
            out_valid_out <= (next_count != '0);
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (push) begin
            mem[wr_ptr] <= in_data_in;
        end
    end
endmodule

// ===== verilog/arl_clk_div.sv
// Purpose: Output clock from the internal clock, divided by 2, 4 or 8
// Assumes: Internal clock is clk_in; level toggles each half period
// Notes:   A started high phase always completes before stopping
`include "arl_defines.svh"
module arl_clk_div (
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    input  wire logic       run_in,
    input  wire logic [1:0] sel_in,
    output logic            level_out,
    output logic            rise_out
);
    logic [2:0] half;
    logic [2:0] cnt;

    always_comb begin
        case (sel_in)
            `ARL_SRC_DIV2: half = `ARL_HALF_DIV2;
            `ARL_SRC_DIV4: half = `ARL_HALF_DIV4;
            default:       half = `ARL_HALF_INT;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            cnt       <= 3'h0;
            level_out <= 1'b0;
            rise_out  <= 1'b0;
        end else begin
            rise_out <= 1'b0;
            if (run_in || level_out) begin
                if (cnt + 3'h1 >= half) begin
                    cnt       <= 3'h0;
                    level_out <= ~level_out;
                    rise_out  <= ~level_out;
                end else begin
                    cnt <= cnt + 3'h1;
                end
            end else begin
                cnt <= 3'h0;
            end
        end
    end
endmodule

// ===== verilog/arl_readout_lanes.sv
// Purpose: Read-side output lanes of a SAR ADC serial port
// Assumes: cs_n_in and sclk_in are synchronous to clk_in (internal clock)
// Notes:   Control fields are taken at each chip-select fall
// Overview of operation
// - Launch edge follows polarity and phase
// - Lane count defaults one; dual/quad selectable
// - Dual lanes drive two bits per launch
// - Quad lanes drive four bits per launch
// - Early launch only for protocol 00/10
// - Early launch moves bits half period earlier
// - Early launch ignored for protocol 01/11
// - Strobe held low during SPI frames
// - Control 00h/01h long frame daisy-chains
// - Other controls zero-fill after 22 bits
// - Source-synchronous mode drives clock on strobe
// - Source select: serial, internal, /2, /4
// - Source-synchronous accepts same lane counts
// - Source-synchronous dual: two bits per rise
// - Source-synchronous quad: four bits per rise
// - Reset gives mode-0 single-lane SPI
// - Standard output mode follows input protocol
`include "arl_defines.svh"
module arl_readout_lanes (
    input  wire logic                       clk_in,
    input  wire logic                       rst_n_in,
    input  wire logic                       cs_n_in,
    input  wire logic                       sclk_in,
    input  wire logic                       chain_in,
    input  wire logic [1:0]                 input_protocol_field_in,
    input  wire logic [7:0]                 output_control_reg_in,
    input  wire logic [`ARL_WORD_BITS-1:0]  word_in,
    input  wire logic                       word_valid_in,
    output logic                            word_ready_out,
    output logic [`ARL_LANES-1:0]           out_lane_out,
    output logic                            ready_strobe_out
);
    arl_pkg::arl_out_ctrl_t   ctrl;
    arl_pkg::arl_state_t      state;
    logic [1:0]               proto;
    logic                     cs_q;
    logic                     sclk_q;
    logic                     cs_fall;
    logic                     cs_rise;
    logic                     sclk_rise;
    logic                     sclk_fall;
    logic [`ARL_WORD_BITS-1:0] sh;
    logic [`ARL_WORD_BITS-1:0] next_sh;
    logic                     primed;
    logic                     next_primed;
    logic [`ARL_CNT_W-1:0]    grp;
    logic [`ARL_CNT_W-1:0]    need;
    logic                     early;
    logic                     on_rise;
    logic                     launch;
    logic                     daisy;
    logic                     fill;
    logic                     div_run;
    logic                     div_level;
    logic                     div_rise;
    logic [`ARL_WORD_BITS-1:0] fifo_data;
    logic                     fifo_valid;
    logic                     fifo_in_ready;
    logic [`ARL_LANES-1:0]    next_lane;

    assign cs_fall   = cs_q && !cs_n_in;
    assign cs_rise   = !cs_q && cs_n_in;
    assign sclk_rise = sclk_in && !sclk_q;
    assign sclk_fall = !sclk_in && sclk_q;

    // Early launch only when capture phase puts first bit at chip-select fall
    assign early   = (ctrl.output_mode_field == `ARL_MODE_EARLY) && !proto[0];
    assign on_rise = (proto == 2'h1) || (proto == 2'h2);
    assign daisy   = (ctrl == arl_pkg::arl_out_ctrl_t'(`ARL_CTRL_DAISY_A)) ||
                     (ctrl == arl_pkg::arl_out_ctrl_t'(`ARL_CTRL_DAISY_B));
    assign fill    = daisy ? chain_in : 1'b0;

    always_comb begin
        case (state)
            arl_pkg::ARL_ST_SPI: launch = ((on_rise ^ early) ? sclk_rise : sclk_fall);
            arl_pkg::ARL_ST_SRC: launch = (ctrl.source_clock_select == `ARL_SRC_SCLK) ?
                                          sclk_rise : div_rise;
            default:             launch = 1'b0;
        endcase
    end

    always_comb begin
        case (ctrl.output_lane_count)
            `ARL_WIDTH_DUAL: need = `ARL_GROUPS_2;
            `ARL_WIDTH_QUAD: need = `ARL_GROUPS_4;
            default:         need = `ARL_GROUPS_1;
        endcase
    end

    // Shift by the active lane count; zeros or chain input refill the tail
    always_comb begin
        next_sh     = sh;
        next_primed = primed;
        if (launch) begin
            if (!primed) begin
                next_primed = 1'b1;
            end else begin
                case (ctrl.output_lane_count)
                    `ARL_WIDTH_DUAL: next_sh = {sh[`ARL_WORD_BITS-3:0], 2'h0};
                    `ARL_WIDTH_QUAD: next_sh = {sh[`ARL_WORD_BITS-5:0], 4'h0};
                    default:         next_sh = {sh[`ARL_WORD_BITS-2:0], fill};
                endcase
            end
        end
    end

    // Lane 0 gets the most significant bit of each group
    genvar gi;
    generate
        for (gi = 0; gi < `ARL_LANES; gi++) begin : g_lane
            always_comb begin
                case (ctrl.output_lane_count)
                    `ARL_WIDTH_DUAL: next_lane[gi] = (gi < 2) && next_sh[`ARL_WORD_BITS-1-gi];
                    `ARL_WIDTH_QUAD: next_lane[gi] = next_sh[`ARL_WORD_BITS-1-gi];
                    default:         next_lane[gi] = (gi == 0) && next_sh[`ARL_WORD_BITS-1];
                endcase
            end
        end
    endgenerate

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            cs_q   <= 1'b1;
            sclk_q <= 1'b0;
        end else begin
            cs_q   <= cs_n_in;
            sclk_q <= sclk_in;
        end
    end

    // Frame state and control taken at chip-select fall
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            state <= arl_pkg::ARL_ST_IDLE;
            ctrl  <= arl_pkg::arl_out_ctrl_t'(`ARL_OUT_CTRL_RESET);
            proto <= `ARL_IN_PROTO_RESET;
        end else begin
            case (state)
                arl_pkg::ARL_ST_IDLE: begin
                    if (cs_fall) begin
                        ctrl  <= arl_pkg::arl_out_ctrl_t'(output_control_reg_in);
                        proto <= input_protocol_field_in;
                        if (output_control_reg_in[`ARL_MODE_LSB+:2] == `ARL_MODE_SRC) begin
                            state <= arl_pkg::ARL_ST_SRC;
                        end else begin
                            state <= arl_pkg::ARL_ST_SPI;
                        end
                    end
                end
                arl_pkg::ARL_ST_SPI,
                arl_pkg::ARL_ST_SRC: begin
                    if (cs_rise) begin
                        state <= arl_pkg::ARL_ST_IDLE;
                    end
                end
                default: state <= arl_pkg::ARL_ST_IDLE;
            endcase
        end
    end

    // Shift register, group counter and first-group flag
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            sh     <= '0;
            primed <= 1'b0;
            grp    <= '0;
        end else if (state == arl_pkg::ARL_ST_IDLE) begin
            if (cs_fall) begin
                sh <= fifo_valid ? fifo_data : '0;
                // Phase-0 protocols show the first group at chip-select fall
                primed <= (output_control_reg_in[`ARL_MODE_LSB+:2] != `ARL_MODE_SRC) &&
                          !input_protocol_field_in[0];
                grp    <= ((output_control_reg_in[`ARL_MODE_LSB+:2] != `ARL_MODE_SRC) &&
                           !input_protocol_field_in[0]) ? 5'h01 : 5'h00;
            end else begin
                primed <= 1'b0;
            end
        end else begin
            sh     <= next_sh;
            primed <= next_primed;
            if (launch && grp != 5'h1F) begin
                grp <= grp + 5'h01;
            end
        end
    end

    // Lanes and strobe leave flip-flops
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            out_lane_out     <= '0;
            ready_strobe_out <= 1'b0;
        end else begin
            if (state == arl_pkg::ARL_ST_IDLE) begin
                out_lane_out <= '0;
            end else begin
                out_lane_out <= next_primed ? next_lane : '0;
            end
            if (state == arl_pkg::ARL_ST_SRC) begin
                ready_strobe_out <= (ctrl.source_clock_select == `ARL_SRC_SCLK) ?
                                    sclk_in : div_level;
            end else begin
                ready_strobe_out <= 1'b0;
            end
        end
    end

    // Buffer's own registered not-full flag; a delayed copy would accept words that the full buffer drops
    assign word_ready_out = fifo_in_ready;

    assign div_run = (state == arl_pkg::ARL_ST_SRC) && !cs_n_in && (grp < need);

    arl_clk_div u_div (
        .clk_in    (clk_in),
        .rst_n_in  (rst_n_in),
        .run_in    (div_run),
        .sel_in    (ctrl.source_clock_select),
        .level_out (div_level),
        .rise_out  (div_rise)
    );

    arl_fifo #(
        .WIDTH (`ARL_WORD_BITS),
        .DEPTH (`ARL_FIFO_DEPTH)
    ) u_fifo (
        .clk_in        (clk_in),
        .rst_n_in      (rst_n_in),
        .in_data_in    (word_in),
        .in_valid_in   (word_valid_in && word_ready_out),
        .in_ready_out  (fifo_in_ready),
        .out_data_out  (fifo_data),
        .out_valid_out (fifo_valid),
        .out_ready_in  ((state == arl_pkg::ARL_ST_IDLE) && cs_fall)
    );

    property p_spi_strobe_low;
        @(posedge clk_in) disable iff (!rst_n_in)
        (state == arl_pkg::ARL_ST_SPI) |=> !ready_strobe_out;
    endproperty
    a_spi_strobe_low: assert property (p_spi_strobe_low) else $error("strobe high in SPI frame");

    property p_reset_default;
        @(posedge clk_in)
        !rst_n_in |=> (ctrl == arl_pkg::arl_out_ctrl_t'(`ARL_OUT_CTRL_RESET)) && (proto == 2'h0)
                      && (state == arl_pkg::ARL_ST_IDLE);
    endproperty
    a_reset_default: assert property (p_reset_default) else $error("reset did not give mode 0");

    property p_early_ignored;
        @(posedge clk_in) disable iff (!rst_n_in)
        (state == arl_pkg::ARL_ST_SPI) && proto[0] && (ctrl.output_mode_field == `ARL_MODE_EARLY) && primed
        && (on_rise ? sclk_fall : sclk_rise) |=> grp == $past(grp);
    endproperty
    a_early_ignored: assert property (p_early_ignored) else $error("early launch with phase 1");

    property p_early_on_capture;
        @(posedge clk_in) disable iff (!rst_n_in)
        (state == arl_pkg::ARL_ST_SPI) && early && primed && (proto == 2'h0) && sclk_rise
        |=> (grp == $past(grp) + 5'h01) || ($past(grp) == 5'h1F);
    endproperty
    a_early_on_capture: assert property (p_early_on_capture) else $error("early launch missed");

    property p_dual_lanes;
        @(posedge clk_in) disable iff (!rst_n_in)
        (state != arl_pkg::ARL_ST_IDLE) && (ctrl.output_lane_count == `ARL_WIDTH_DUAL) && launch && primed
        |=> out_lane_out[1:0] == {$past(sh[`ARL_WORD_BITS-4]), $past(sh[`ARL_WORD_BITS-3])}
            && out_lane_out[3:2] == 2'h0;
    endproperty
    a_dual_lanes: assert property (p_dual_lanes) else $error("dual lanes wrong");

    property p_quad_lanes;
        @(posedge clk_in) disable iff (!rst_n_in)
        (state != arl_pkg::ARL_ST_IDLE) && (ctrl.output_lane_count == `ARL_WIDTH_QUAD) && launch && primed
        |=> out_lane_out == {<<{$past(sh[`ARL_WORD_BITS-5 -: 4])}};
    endproperty
    a_quad_lanes: assert property (p_quad_lanes) else $error("quad lanes wrong");

    property p_zero_fill;
        @(posedge clk_in) disable iff (!rst_n_in)
        (state == arl_pkg::ARL_ST_SPI) && !daisy && (grp > need) && primed |=> out_lane_out == '0;
    endproperty
    a_zero_fill: assert property (p_zero_fill) else $error("no zero fill after word");

    property p_src_clock;
        @(posedge clk_in) disable iff (!rst_n_in)
        (state == arl_pkg::ARL_ST_SRC) && (ctrl.source_clock_select != `ARL_SRC_SCLK) && div_rise
        |=> ready_strobe_out;
    endproperty
    a_src_clock: assert property (p_src_clock) else $error("strobe not following output clock");

    property p_first_at_cs;
        @(posedge clk_in) disable iff (!rst_n_in)
        (state == arl_pkg::ARL_ST_IDLE) && cs_fall && !input_protocol_field_in[0]
        && (output_control_reg_in[`ARL_MODE_LSB+:2] != `ARL_MODE_SRC) |=> primed;
    endproperty
    a_first_at_cs: assert property (p_first_at_cs) else $error("first bit not at chip-select fall");

    c_quad_spi:  cover property (@(posedge clk_in) (state == arl_pkg::ARL_ST_SPI) && grp == `ARL_GROUPS_4
                                  && ctrl.output_lane_count == `ARL_WIDTH_QUAD);
    c_src_div4:  cover property (@(posedge clk_in) (state == arl_pkg::ARL_ST_SRC) && div_rise
                                  && ctrl.source_clock_select == `ARL_SRC_DIV4);
    c_daisy:     cover property (@(posedge clk_in) (state == arl_pkg::ARL_ST_SPI) && daisy && grp > need);
endmodule

// ===== testbench/arl_host_model.sv
// Purpose: Host controller model driving chip select and serial clock
// Assumes: Lanes settle one clk_in cycle after the block sees a launch edge
// Notes:   Reads only; samples lanes just before every serial clock edge in SPI frames, at each strobe rise in source-synchronous frames
module arl_host_model (
    input  wire logic       clk_in,
    output logic            cs_n_out,
    output logic            sclk_out,
    input  wire logic [3:0] lane_in,
    input  wire logic       strobe_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] smp [64];
    logic       strb_seen;
    int         n_smp;
    int         gap;

    initial begin
        cs_n_out = 1'b1;
        sclk_out = 1'b0;
    end

    // Levels last three cycles so a launch has settled before the next edge
    task automatic spi_frame(input logic pol, input int cycles);
        strb_seen = 1'b0;
        @(posedge clk_in) sclk_out <= pol;
        @(posedge clk_in) cs_n_out <= 1'b0;
        repeat (2) @(posedge clk_in);
        for (int j = 0; j < 2 * cycles; j++) begin
            @(negedge clk_in);
            smp[j] = lane_in;
            strb_seen = strb_seen | strobe_in;
            @(posedge clk_in) sclk_out <= ~sclk_out;
            repeat (2) @(posedge clk_in);
        end
        @(posedge clk_in) cs_n_out <= 1'b1;
        @(posedge clk_in);
    endtask

    // Catches lanes at each strobe rise; serial clock only runs for given edges
    task automatic src_frame(input int edges, input int span);
        int   first;
        int   tog;
        logic prev;
        n_smp = 0;
        gap = 0;
        first = 0;
        tog = 0;
        prev = 1'b0;
        @(posedge clk_in) sclk_out <= 1'b0;
        @(posedge clk_in) cs_n_out <= 1'b0;
        for (int t = 0; t < span; t++) begin
            @(negedge clk_in);
            if (strobe_in && !prev && n_smp < 64) begin
                if (n_smp == 1) gap = t - first;
                if (n_smp == 0) first = t;
                smp[n_smp] = lane_in;
                n_smp++;
            end
            prev = strobe_in;
            @(posedge clk_in);
            if (t % 2 == 1 && tog < edges) begin
                sclk_out <= ~sclk_out;
                tog++;
            end
        end
        cs_n_out <= 1'b1;
        @(posedge clk_in);
    endtask
endmodule

// ===== testbench/arl_readout_lanes_tb.sv
// Purpose: Self-checking bench for the readout lanes block
// Assumes: Host model owns chip select and serial clock
// Notes:   Random words with seed 47, corner words fill the buffer first
module arl_readout_lanes_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_in;
    logic        rst_n_in;
    logic        cs_n, sclk, chain, word_valid, word_ready, strobe;
    logic [1:0]  proto;
    logic [7:0]  ctrl;
    logic [21:0] word;
    logic [3:0]  lanes;
    logic [21:0] fw [4];
    logic [7:0]  sc [6] = '{8'h00, 8'h01, 8'h08, 8'h09, 8'h0C, 8'h0D};
    logic [1:0]  lcs [3] = '{2'h0, 2'h2, 2'h3};
    int          bad_count;
    int          checks_done;

    arl_readout_lanes uut (.clk_in(clk_in), .rst_n_in(rst_n_in), .cs_n_in(cs_n), .sclk_in(sclk),
        .chain_in(chain), .input_protocol_field_in(proto), .output_control_reg_in(ctrl), .word_in(word),
        .word_valid_in(word_valid), .word_ready_out(word_ready), .out_lane_out(lanes),
        .ready_strobe_out(strobe));
    arl_host_model host (.clk_in(clk_in), .cs_n_out(cs_n), .sclk_out(sclk), .lane_in(lanes), .strobe_in(strobe));

    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    task automatic conclude();
        if (bad_count == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk_lane(input logic [3:0] got, input logic [3:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_num(input int got, input int exp);
        checks_done++;
        if (got != exp) begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Lane 0 takes the earliest bit of each group; bits past the word are the tail
    function automatic logic [3:0] grp(input logic [21:0] w, input int g, input int n, input logic tl);
        logic [3:0] r;
        int         p;
        r = 4'h0;
        for (int l = 0; l < n; l++) begin
            p = g * n + l;
            r[l] = (p < 22) ? w[21-p] : tl;
        end
        return r;
    endfunction

    task automatic push(input logic [21:0] w);
        int i;
        @(posedge clk_in);
        word <= w;
        word_valid <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(negedge clk_in);
            if (word_ready === 1'b1) break;
        end
        if (i == 20) begin
            bad_count++;
            conclude();
        end
        @(posedge clk_in);
        word_valid <= 1'b0;
    endtask

    task automatic run_spi(input logic [1:0] pr, input logic [7:0] cw, input logic [21:0] w, input logic t);
        int   nl;
        int   ng;
        int   g;
        logic early;
        logic tl;
        nl = (cw[3:2] == 2'h3) ? 4 : (cw[3:2] == 2'h2) ? 2 : 1;
        ng = (22 + nl - 1) / nl + 2;
        early = (cw[1:0] == 2'h1) && !pr[0];
        tl = (cw == 8'h00 || cw == 8'h01) ? t : 1'b0;
        proto <= pr;
        ctrl <= cw;
        host.spi_frame(pr[1], ng);
        for (int j = 0; j < 2 * ng; j++) begin
            g = pr[0] ? (j - 1) / 2 : early ? (j + 1) / 2 : j / 2;
            if (!(pr[0] && j == 0)) chk_lane(host.smp[j], grp(w, g, nl, tl));
        end
        chk_lane({3'h0, host.strb_seen}, 4'h0);
    endtask

    task automatic run_src(input logic [1:0] sel, input logic [1:0] lc, input logic [21:0] w);
        int nl;
        int ng;
        nl = (lc == 2'h3) ? 4 : (lc == 2'h2) ? 2 : 1;
        ng = (22 + nl - 1) / nl;
        proto <= 2'($urandom);
        ctrl <= {sel, 2'h0, lc, 2'h3};
        host.src_frame((sel == 2'h0) ? 2 * ng : 0, 200);
        chk_num(host.n_smp, ng);
        chk_num(host.gap, (sel == 2'h1) ? 2 : (sel == 2'h3) ? 8 : 4);
        for (int i = 0; i < ng && i < host.n_smp; i++) chk_lane(host.smp[i], grp(w, i, nl, 1'b0));
    endtask

    initial begin
        int          n;
        int          c;
        logic        ok;
        logic        tail;
        logic [21:0] ew;
        void'($urandom(47));
        bad_count = 0;
        checks_done = 0;
        rst_n_in = 1'b0;
        chain = 1'b0;
        proto = 2'h0;
        ctrl = 8'h00;
        word = 22'h0;
        word_valid = 1'b0;
        repeat (2) @(posedge clk_in);
        rst_n_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        @(negedge clk_in);
        chk_lane(lanes, 4'h0);
        chk_lane({3'h0, strobe}, 4'h0);
        fw[0] = 22'h3FFFFF;
        fw[1] = 22'h000001;
        fw[2] = 22'($urandom);
        fw[3] = 22'($urandom);
        // Hold valid for eight cycles, past the point where the buffer refuses
        n = 0;
        @(posedge clk_in);
        word <= fw[0];
        word_valid <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            @(negedge clk_in);
            ok = word_ready;
            @(posedge clk_in);
            if (ok === 1'b1) begin
                n++;
                word <= fw[n%4];
            end
        end
        word_valid <= 1'b0;
        chk_num(n, 4);
        // Four buffered words, one empty pop, then one fresh word per frame
        for (int k = 0; k < 41; k++) begin
            c = k % 36;
            ew = (k < 4) ? fw[k] : 22'h0;
            if (k > 4) begin
                ew = 22'($urandom);
                push(ew);
            end
            @(posedge clk_in);
            tail = 1'($urandom);
            chain <= tail;
            if (c < 24) run_spi(2'(c / 6), sc[c%6], ew, tail);
            else run_src(2'((c - 24) / 3), lcs[(c-24)%3], ew);
        end
        conclude();
    end
endmodule
